// ### core/mmbi_top.sv
// Memory bus interface: strobe sequencer, bus multiplexer, alternate pins
`timescale 1ns/1ps
`default_nettype none
module mmbi_top
    import mmbi_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_osc_edge,
    output logic             o_cpu_clk_en,
    output logic             o_quarter_en,
    output logic             o_core_reset,
    input  wire logic        i_powerup_rst_low,
    input  wire logic        i_req,
    input  wire logic        i_req_write,
    input  wire logic        i_req_core,
    input  wire logic        i_req_video,
    input  wire logic [31:0] i_req_addr,
    input  wire logic [31:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_done,
    output logic             o_cancel,
    output logic             o_fault_trap,
    output logic [31:0]      o_rdata,
    input  wire logic        i_single_bank_mode,
    input  wire logic        i_fault_pin_sel,
    input  wire logic        i_input_pin_sel,
    input  wire logic        i_read_en_cfg,
    input  wire logic [3:0]  i_early_at_col,
    input  wire logic [3:0]  i_late_after,
    input  wire logic [3:0]  i_page_mode,
    input  wire logic [15:0] i_t_row,
    input  wire logic [15:0] i_t_col,
    input  wire logic [15:0] i_t_data,
    input  wire logic        i_out_we,
    input  wire logic [7:0]  i_out_wdata,
    output logic [7:0]       o_out_bits,
    output logic [7:0]       o_in_bits,
    input  wire logic [7:0]  i_in_n,
    input  wire logic        i_memory_fault_in_n,
    input  wire logic        i_ext_rstn,
    input  wire logic [31:0] i_ad,
    output logic [31:0]      o_ad,
    output logic [31:0]      o_ad_oe,
    output logic             o_row_n,
    output logic             o_row,
    output logic             o_col_n,
    output logic             o_col,
    output logic [3:0]       o_group_select_strobes_n,
    output logic [3:0]       o_bank_column_strobes_n,
    output logic             o_read_en_n,
    output logic             o_early_write_strobe_n,
    output logic             o_late_write_strobe_n,
    output logic             o_data_output_strobe_n,
    output logic             o_video_special_function
);
    // ----------------------------------------------------------------
    // Reset release and clock enables
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rstn;
    logic [1:0] div_reg;
    logic       alt_mode_reg;
    logic       alt_rst_reg;
    logic [2:0] ext_rst_reg;
    logic       pin_rst_reg;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rstn = rst_sync_reg[1];

    // Two cpu enables per oscillator period, four quarter steps
    always_ff @(posedge i_clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 2'h0;
        end else if (i_osc_edge) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign o_quarter_en = 1'b1;
    assign o_cpu_clk_en = div_reg[0];

    // Strap captured after release: alternate reset source
    always_ff @(posedge i_clk_sys or negedge rstn) begin
        if (!rstn) begin
            alt_mode_reg <= 1'b0;
            ext_rst_reg  <= 3'h7;
            pin_rst_reg  <= 1'b0;
        end else begin
            if (!pin_rst_reg) begin
                alt_mode_reg <= !i_powerup_rst_low;
                pin_rst_reg  <= 1'b1;
            end
            ext_rst_reg <= {ext_rst_reg[1:0], i_ext_rstn};
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] in_s1_reg, in_s2_reg, in_s3_reg;
    logic [2:0] flt_reg;
    logic [31:0] ad_s1_reg, ad_s2_reg, ad_s3_reg;

    always_ff @(posedge i_clk_sys or negedge rstn) begin
        if (!rstn) begin
            in_s1_reg <= 8'hFF;
            in_s2_reg <= 8'hFF;
            in_s3_reg <= 8'hFF;
            flt_reg   <= 3'h7;
            ad_s1_reg <= 32'h0;
            ad_s2_reg <= 32'h0;
            ad_s3_reg <= 32'h0;
        end else begin
            in_s1_reg <= i_in_n;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
            flt_reg   <= {flt_reg[1:0], i_memory_fault_in_n};
            ad_s1_reg <= i_ad;
            ad_s2_reg <= ad_s1_reg;
            ad_s3_reg <= ad_s2_reg;
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    mmbi_state_type state_reg, state_next;
    logic [3:0]  cnt_reg;
    logic [1:0]  grp_reg;
    logic [1:0]  bank_reg;
    logic        wr_reg, core_reg, vid_reg;
    logic [31:0] addr_reg, wdata_reg;
    logic [15:0] open_row_reg;
    logic        row_open_reg;
    logic        fault_reg;
    logic [1:0]  req_grp;
    logic        page_hit;
    logic        tick_done;
    logic [3:0]  t_sel;
    logic        pin_fault, ad_fault;
    logic        row_act, col_act;

    assign req_grp   = i_req_addr[31:30];
    assign page_hit  = row_open_reg && i_page_mode[req_grp]
                       && (grp_reg == req_grp)
                       && (open_row_reg == i_req_addr[29:14]);
    assign t_sel     = (state_reg == ST_ROW) ? i_t_row[grp_reg*4 +: 4] :
                       (state_reg == ST_COL) ? i_t_col[grp_reg*4 +: 4] :
                       i_t_data[grp_reg*4 +: 4];
    assign tick_done = (cnt_reg >= t_sel) || (t_sel < MMBI_T_MIN);
    assign pin_fault = i_fault_pin_sel && !flt_reg[2] && !flt_reg[1];
    assign ad_fault  = !i_fault_pin_sel && !ad_s3_reg[MMBI_ALT_BIT]
                       && !ad_s2_reg[MMBI_ALT_BIT];
    assign o_req_ready = (state_reg == ST_IDLE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_req) begin
                    state_next = page_hit ? ST_COL : ST_PRE;
                end
            end
            ST_PRE:  if (tick_done) state_next = ST_ROW;
            ST_ROW: begin
                if (fault_reg) begin
                    state_next = ST_IDLE;
                end else if (tick_done) begin
                    state_next = ST_COL;
                end
            end
            ST_COL:  if (tick_done) state_next = ST_DATA;
            ST_DATA: if (tick_done) state_next = ST_END;
            ST_END:  state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 4'h0;
            grp_reg      <= 2'h0;
            bank_reg     <= 2'h0;
            wr_reg       <= 1'b0;
            core_reg     <= 1'b0;
            vid_reg      <= 1'b0;
            addr_reg     <= 32'h0;
            wdata_reg    <= 32'h0;
            open_row_reg <= 16'h0;
            row_open_reg <= 1'b0;
            fault_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'h1;
            if (state_reg == ST_IDLE && i_req) begin
                grp_reg   <= req_grp;
                bank_reg  <= i_req_addr[13:12];
                wr_reg    <= i_req_write;
                core_reg  <= i_req_core;
                vid_reg   <= i_req_video;
                addr_reg  <= i_req_addr;
                wdata_reg <= i_req_wdata;
                fault_reg <= 1'b0;
                if (!page_hit) begin
                    row_open_reg <= 1'b0;
                end
            end
            if (state_reg == ST_PRE && pin_fault) begin
                fault_reg <= 1'b1;
            end
            if (state_reg == ST_PRE && tick_done) begin
                fault_reg    <= fault_reg || pin_fault || ad_fault;
                open_row_reg <= addr_reg[29:14];
                row_open_reg <= 1'b1;
            end
            if (state_reg == ST_ROW && fault_reg) begin
                row_open_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus results and bit I/O
    // ----------------------------------------------------------------
    logic [7:0] out_reg, in_reg;
    logic       done_reg, cancel_reg;
    logic [31:0] rdata_reg;
    logic       in_sample;
    logic [2:0] win_reg;

    assign in_sample = row_act && !col_act && (o_ad_oe == 32'h0);
    always_ff @(posedge i_clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_reg     <= MMBI_OUT_RST;
            in_reg      <= 8'h0;
            done_reg    <= 1'b0;
            cancel_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            alt_rst_reg <= 1'b0;
            win_reg     <= 3'h0;
        end else begin
            if (i_out_we) begin
                out_reg <= i_out_wdata;
            end
            win_reg <= {win_reg[1:0], in_sample};
            if (i_input_pin_sel) begin
                if (in_s3_reg == in_s2_reg) begin
                    in_reg <= ~in_s3_reg;
                end
            end else if (win_reg[2] && win_reg[1]
                         && (ad_s3_reg[7:0] == ad_s2_reg[7:0])) begin
                in_reg <= ad_s3_reg[7:0];
            end
            alt_rst_reg <= alt_mode_reg && win_reg[2] && win_reg[1]
                           && !ad_s3_reg[MMBI_ALT_BIT]
                           && !ad_s2_reg[MMBI_ALT_BIT];
            done_reg   <= (state_reg == ST_END);
            cancel_reg <= (state_reg == ST_ROW) && fault_reg;
            if (state_reg == ST_DATA && tick_done && !wr_reg) begin
                rdata_reg <= ad_s3_reg;
            end
        end
    end

    // Whole device restart from pin or alternate source
    assign o_core_reset = !rst_sync_reg[1] || alt_rst_reg
                          || (!alt_mode_reg && !ext_rst_reg[2]
                              && !ext_rst_reg[1]);
    assign o_out_bits   = out_reg;
    assign o_in_bits    = in_reg;
    assign o_done       = done_reg;
    assign o_cancel     = cancel_reg;
    assign o_fault_trap = cancel_reg;
    assign o_rdata      = rdata_reg;

    // ----------------------------------------------------------------
    // Strobes and bus drive
    // ----------------------------------------------------------------
    logic       active;
    logic       col_phase_hit;
    logic [3:0] grp_dec, bank_dec;

    assign active   = (state_reg != ST_IDLE);
    assign row_act  = row_open_reg && (state_reg != ST_PRE);
    assign col_act  = (state_reg == ST_COL) || (state_reg == ST_DATA);
    assign grp_dec  = 4'h1 << grp_reg;
    assign bank_dec = 4'h1 << bank_reg;
    assign col_phase_hit = (state_reg == ST_DATA);

    always_comb begin
        o_row_n = !row_act;
        o_row   = row_act;
        o_col_n = !col_act;
        o_col   = col_act;
        o_group_select_strobes_n = i_single_bank_mode
            ? ~(grp_dec & {4{row_act}})
            : ~(grp_dec & {4{active}});
        o_bank_column_strobes_n = ~(bank_dec & {4{col_act}});
        o_read_en_n = !(i_read_en_cfg && active && !wr_reg
                        && col_phase_hit);
        o_early_write_strobe_n = !(wr_reg && (i_early_at_col[grp_reg]
                                 ? col_act : active));
        o_data_output_strobe_n = !(wr_reg && col_phase_hit);
        o_late_write_strobe_n  = !((wr_reg || vid_reg) && col_phase_hit
                                 && (!i_late_after[grp_reg]
                                     || cnt_reg != 4'h0));
        o_video_special_function = core_reg && vid_reg
                                   && (row_act || col_act);
        // Bus shares address, data and bit outputs
        if (!row_act) begin
            o_ad    = {24'h0, out_reg};
            o_ad_oe = {24'h0, 8'hFF};
        end else if (state_reg == ST_ROW) begin
            o_ad    = addr_reg;
            o_ad_oe = 32'hFFFFFFFF;
        end else if (state_reg == ST_COL) begin
            o_ad    = {18'h0, addr_reg[13:0]};
            o_ad_oe = 32'hFFFFFFFF;
        end else if (wr_reg && col_phase_hit) begin
            o_ad    = wdata_reg;
            o_ad_oe = 32'hFFFFFFFF;
        end else begin
            o_ad    = 32'h0;
            o_ad_oe = 32'h0;
        end
    end
endmodule // mmbi_top
`default_nettype wire

// ### include/mmbi_pkg.sv
// Constants and types for the multiplexed memory bus interface
package mmbi_pkg;
    localparam int          MMBI_GROUPS     = 4;
    localparam int          MMBI_BANKS      = 4;
    localparam int          MMBI_BUS_W      = 32;
    localparam int          MMBI_IO_W       = 8;
    localparam int          MMBI_TW         = 4;
    localparam int          MMBI_ALT_BIT    = 8;
    localparam logic [7:0]  MMBI_OUT_RST    = 8'hFF;
    localparam logic [3:0]  MMBI_T_MIN      = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_COL,
        ST_DATA,
        ST_END,
        ST_PRE
    } mmbi_state_type;
endpackage : mmbi_pkg

// ### verif/mmbi_chk.sv
// Concurrent checks on the memory bus interface ports
`timescale 1ns/1ps
`default_nettype none
module mmbi_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_rstn,
    input wire logic       i_req,
    input wire logic       i_single_bank_mode,
    input wire logic       o_req_ready,
    input wire logic       o_done,
    input wire logic       o_cancel,
    input wire logic       o_fault_trap,
    input wire logic       o_row_n,
    input wire logic       o_row,
    input wire logic       o_col_n,
    input wire logic       o_col,
    input wire logic [3:0] o_group_select_strobes_n,
    input wire logic [3:0] o_bank_column_strobes_n,
    input wire logic       o_read_en_n,
    input wire logic       o_early_write_strobe_n,
    input wire logic       o_late_write_strobe_n
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_row_inverted: assert property (o_row == !o_row_n)
        else $error("row strobe pair not complementary");
    a_col_inverted: assert property (o_col == !o_col_n)
        else $error("column strobe pair not complementary");
    a_col_needs_row: assert property (!o_col_n |-> !o_row_n)
        else $error("column strobe active without row strobe");
    a_bank_with_col: assert property (
        (o_bank_column_strobes_n != 4'hF) |-> !o_col_n)
        else $error("bank column strobe active without column strobe");
    a_group_one_only: assert property (
        !i_single_bank_mode |-> $onehot0(~o_group_select_strobes_n))
        else $error("more than one group select active");
    a_read_no_write: assert property (
        !o_read_en_n |-> o_early_write_strobe_n && o_late_write_strobe_n)
        else $error("read enable together with a write strobe");
    a_done_single: assert property (o_done |=> !o_done)
        else $error("done pulse longer than one cycle");
    a_take_refuse: assert property (o_req_ready && i_req |=> !o_req_ready)
        else $error("ready still high after a request was taken");
    a_take_answer: assert property (
        o_req_ready && i_req |-> ##[2:200] (o_done || o_cancel))
        else $error("bus cycle did not end in time");
    a_trap_cancel: assert property (
        o_fault_trap |-> o_cancel && o_row_n && o_col_n)
        else $error("trap without cancelled and closed cycle");
endmodule : mmbi_chk

bind mmbi_top mmbi_chk u_mmbi_chk (
    .i_clk_sys, .i_rstn, .i_req, .i_single_bank_mode, .o_req_ready,
    .o_done, .o_cancel, .o_fault_trap, .o_row_n, .o_row, .o_col_n, .o_col,
    .o_group_select_strobes_n, .o_bank_column_strobes_n, .o_read_en_n,
    .o_early_write_strobe_n, .o_late_write_strobe_n);
`default_nettype wire

// ### verif/mmbi_mem_model.sv
// Far-side model: memory and fault logic on the shared bus
`timescale 1ns/1ps
`default_nettype none
module mmbi_mem_model (
    input wire logic        i_clk_sys,
    input wire logic [31:0] i_ad_out,
    input wire logic [31:0] i_ad_oe,
    input wire logic        i_row_n,
    input wire logic        i_col_n,
    input wire logic        i_read_en_n,
    input wire logic [31:0] i_rd_word,
    input wire logic [7:0]  i_in_pat,
    input wire logic        i_fault_arm,
    output logic [31:0]     o_ad,
    output logic            o_memory_fault_in_n
);
    logic [31:0] last_reg = 32'h0;
    logic [31:0] far_val;

    always @(posedge i_clk_sys) last_reg <= o_ad;
    // Read word while enabled; bit 8 held low while armed, inputs as given while row strobe active and column strobe inactive
    assign far_val = !i_read_en_n ? i_rd_word :
        (!i_row_n && i_col_n)
            ? {~last_reg[31:9], ~i_fault_arm, i_in_pat}
            : {~last_reg[31:9], ~(i_fault_arm | last_reg[8]),
               ~last_reg[7:0]};
    assign o_ad = (i_ad_out & i_ad_oe) | (far_val & ~i_ad_oe);
    assign o_memory_fault_in_n = ~(i_fault_arm && i_row_n);
endmodule : mmbi_mem_model
`default_nettype wire

// ### verif/mmbi_tb_top.sv
// Self-checking bench for the multiplexed memory bus interface
`timescale 1ns/1ps
`default_nettype none
module mmbi_tb_top;
    import mmbi_pkg::*;
    logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_osc_edge = 1'b0;
    logic        i_powerup_rst_low = 1'b1, i_req = 1'b0, i_req_write = 1'b0;
    logic        i_req_core = 1'b1, i_req_video = 1'b0, i_ext_rstn = 1'b1;
    logic        i_single_bank_mode = 1'b0, i_fault_pin_sel = 1'b0;
    logic        i_input_pin_sel = 1'b1, i_read_en_cfg = 1'b1, i_out_we = 1'b0;
    logic [3:0]  i_early_at_col = 4'h0, i_late_after = 4'h0, i_page_mode = 4'h0;
    logic [15:0] i_t_row = 16'h2222, i_t_col = 16'h2222, i_t_data = 16'h4444;
    logic [31:0] i_req_addr = 32'h0, i_req_wdata = 32'h0, rd_word = 32'h0;
    logic [7:0]  i_out_wdata = 8'h00, i_in_n = 8'hFF, out_exp = 8'hFF;
    logic        fault_arm = 1'b0, i_memory_fault_in_n;
    logic [31:0] i_ad, o_rdata, o_ad, o_ad_oe;
    logic        o_cpu_clk_en, o_quarter_en, o_core_reset, o_req_ready, o_done;
    logic        o_cancel, o_fault_trap, o_row_n, o_row, o_col_n, o_col;
    logic        o_read_en_n, o_early_write_strobe_n, o_late_write_strobe_n;
    logic        o_data_output_strobe_n, o_video_special_function;
    logic [7:0]  o_out_bits, o_in_bits;
    logic [3:0]  o_group_select_strobes_n, o_bank_column_strobes_n, s_grp, s_bank;
    logic        s_row, s_ewe, s_oe, s_sf, s_rise, s_done, s_cancel, s_trap;
    logic        s_lwe, s_dob, s_lead, s_ewe0;
    int          errors = 0, compares = 0;

    always #10 i_clk_sys = ~i_clk_sys;
    always begin
        repeat (3) @(posedge i_clk_sys);
        #1 i_osc_edge = 1'b1;
        @(posedge i_clk_sys);
        #1 i_osc_edge = 1'b0;
    end

    mmbi_top u_mmbi_top (
        .i_clk_sys, .i_rstn, .i_osc_edge, .o_cpu_clk_en, .o_quarter_en,
        .o_core_reset, .i_powerup_rst_low, .i_req, .i_req_write, .i_req_core,
        .i_req_video, .i_req_addr, .i_req_wdata, .o_req_ready, .o_done,
        .o_cancel, .o_fault_trap, .o_rdata, .i_single_bank_mode,
        .i_fault_pin_sel, .i_input_pin_sel, .i_read_en_cfg, .i_early_at_col,
        .i_late_after, .i_page_mode, .i_t_row, .i_t_col, .i_t_data, .i_out_we,
        .i_out_wdata, .o_out_bits, .o_in_bits, .i_in_n, .i_memory_fault_in_n,
        .i_ext_rstn, .i_ad, .o_ad, .o_ad_oe, .o_row_n, .o_row, .o_col_n,
        .o_col, .o_group_select_strobes_n, .o_bank_column_strobes_n,
        .o_read_en_n, .o_early_write_strobe_n, .o_late_write_strobe_n,
        .o_data_output_strobe_n, .o_video_special_function);
    mmbi_mem_model u_mmbi_mem_model (
        .i_clk_sys, .i_ad_out(o_ad), .i_ad_oe(o_ad_oe), .i_row_n(o_row_n),
        .i_col_n(o_col_n), .i_read_en_n(o_read_en_n), .i_rd_word(rd_word),
        .i_in_pat(8'h3C), .i_fault_arm(fault_arm), .o_ad(i_ad),
        .o_memory_fault_in_n(i_memory_fault_in_n));

    task automatic chk_vec(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        compares++;
        if (e !== g) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a);
        logic rdy;
        {s_grp, s_bank, s_row, s_ewe, s_oe, s_sf, s_rise} = 15'h0;
        {s_done, s_cancel, s_trap, rdy, s_lwe, s_dob, s_lead, s_ewe0} = 8'h0;
        i_req_write = w;
        i_req_addr = a;
        i_req_wdata = ~a;
        i_req = 1'b1;
        for (int n = 0; n < 50 && !rdy; n++) begin
            rdy = o_req_ready;
            wait_clk(1);
        end
        i_req = 1'b0;
        for (int n = 0; n < 200 && !(s_done || s_cancel); n++) begin
            if (o_row_n && o_ad_oe[7:0] == 8'hFF)
                chk_vec("out bits on bus", {24'h0, out_exp}, {24'h0, o_ad[7:0]});
            s_rise |= s_row && o_row_n;
            s_row |= !o_row_n;
            s_grp |= ~o_group_select_strobes_n;
            s_bank |= ~o_bank_column_strobes_n;
            s_ewe |= !o_early_write_strobe_n;
            s_ewe0 |= !o_early_write_strobe_n && o_col_n;
            s_lead |= !o_late_write_strobe_n && !o_data_output_strobe_n
                      && !s_dob;
            s_dob |= !o_data_output_strobe_n;
            s_lwe |= !o_late_write_strobe_n;
            s_oe |= !o_read_en_n;
            s_sf |= o_video_special_function;
            {s_done, s_cancel, s_trap} = {o_done, o_cancel, o_fault_trap};
            wait_clk(1);
        end
        chk_vec("cycle ended", 32'h1, {31'h0, s_done || s_cancel});
    endtask

    task automatic t_reset_clock;
        int n = 0, q = 0;
        chk_vec("strobes idle", 32'h3, {30'h0, o_row_n, o_col_n});
        chk_vec("out bits reset", 32'hFF, {24'h0, o_out_bits});
        for (int k = 0; k < 8; k++) begin
            n += o_cpu_clk_en;
            q += o_quarter_en;
            wait_clk(1);
        end
        chk_vec("cpu enables", 32'h4, n);
        chk_vec("quarter steps", 32'h8, q);
    endtask
    task automatic t_write_read;
        for (int m = 0; m < 2; m++) begin
            {i_single_bank_mode, i_early_at_col, i_late_after} = {9{m[0]}};
            xfer(1'b1, 32'h8012_1ABC);
            chk_vec("write group", 32'h1, {31'h0, s_grp[2]});
            chk_vec("write bank", 32'h2, {28'h0, s_bank});
            chk_vec("write strobes", 32'h5, {29'h0, s_ewe, s_oe, s_row});
            chk_vec("early write", {31'h0, !m[0]}, {31'h0, s_ewe0});
            chk_vec("late write", {29'h0, 2'b11, !m[0]},
                    {29'h0, s_dob, s_lwe, s_lead});
        end
        i_single_bank_mode = 1'b0;
        rd_word = 32'h5A3C_96E1;
        xfer(1'b0, 32'h4000_3004);
        chk_vec("read group bank", 32'h28, {24'h0, s_grp, s_bank});
        chk_vec("read strobes", 32'h1, {30'h0, s_ewe, s_oe});
        chk_vec("read late write", 32'h0, {30'h0, s_dob, s_lwe});
        chk_vec("read data", 32'h5A3C_96E1, o_rdata);
    endtask
    task automatic t_video_page;
        i_req_video = 1'b1;
        xfer(1'b1, 32'hC000_0010);
        chk_vec("video function", 32'h1, {31'h0, s_sf});
        i_req_video = 1'b0;
        i_page_mode = 4'h1;
        xfer(1'b1, 32'h0000_4000);
        xfer(1'b0, 32'h0000_4000);
        chk_vec("page hit row held", 32'h0, {31'h0, s_rise});
        i_page_mode = 4'h0;
    endtask
    task automatic t_bits_fault;
        {i_out_we, i_out_wdata, out_exp} = {1'b1, 8'hC3, 8'hC3};
        wait_clk(1);
        i_out_we = 1'b0;
        i_in_n = 8'h5A;
        wait_clk(6);
        chk_vec("out bits", 32'hC3, {24'h0, o_out_bits});
        chk_vec("pin inputs", 32'hA5, {24'h0, o_in_bits});
        xfer(1'b1, 32'h4000_0000);
        {i_fault_pin_sel, fault_arm} = 2'b11;
        wait_clk(6);
        xfer(1'b1, 32'h4000_8000);
        chk_vec("fault trap", 32'h3, {30'h0, s_cancel, s_trap});
        i_fault_pin_sel = 1'b0;
        xfer(1'b1, 32'h4001_0000);
        chk_vec("bus fault", 32'h3, {30'h0, s_cancel, s_trap});
        {i_fault_pin_sel, fault_arm, i_ext_rstn} = 3'b000;
        wait_clk(6);
        chk_vec("pin reset", 32'h1, {31'h0, o_core_reset});
        i_ext_rstn = 1'b1;
    endtask
    task automatic t_bus_pins;
        i_input_pin_sel = 1'b0;
        xfer(1'b1, 32'h0000_0100);
        wait_clk(6);
        chk_vec("bus inputs", 32'h3C, {24'h0, o_in_bits});
        {i_powerup_rst_low, i_rstn, out_exp} = {2'b00, 8'hFF};
        wait_clk(2);
        i_rstn = 1'b1;
        wait_clk(4);
        chk_vec("out bits after reset", 32'hFF, {24'h0, o_out_bits});
        i_ext_rstn = 1'b0;
        xfer(1'b1, 32'h0000_0100);
        wait_clk(6);
        chk_vec("pin reset ignored", 32'h0, {31'h0, o_core_reset});
        fault_arm = 1'b1;
        wait_clk(6);
        chk_vec("bus reset", 32'h1, {31'h0, o_core_reset});
        {fault_arm, i_ext_rstn} = 2'b01;
    endtask

    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        print_verdict();
    end
    initial begin
        wait_clk(8);
        i_rstn = 1'b1;
        wait_clk(4);
        t_reset_clock();
        t_write_read();
        t_video_page();
        t_bits_fault();
        t_bus_pins();
        print_verdict();
    end
endmodule : mmbi_tb_top
`default_nettype wire
